// ---- src/etcc_pkg.sv ----
// package for the elapsed time capture counter: widths, selector codes, timing
// assumes a single 100 MHz mclk domain; pins arrive asynchronous to it
package etcc_pkg;
  // ----------------------------------------
  // widths and selector codes
  // ----------------------------------------
  localparam int ETCC_CNT_W = 40;
  localparam logic [5:0] ETCC_PIN_FUNC_TRIG = 6'h27;  // pin function code for trigger
  localparam logic ETCC_VCO_THIRD = 1'b0;
  localparam logic ETCC_VCO_SECOND = 1'b1;
  localparam logic ETCC_TRIG_PIN = 1'b1;
  localparam logic ETCC_TRIG_SPI = 1'b0;
  localparam int ETCC_DIV_THIRD = 8;
  localparam int ETCC_DIV_SECOND = 20;
  localparam int ETCC_DIV_W = 5;
  localparam logic [ETCC_CNT_W-1:0] ETCC_CNT_RST = 40'h00_0000_0000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int ETCC_CLK_PERIOD_PS = 10000;
  localparam int ETCC_REARM_TIME_NS = 1000;
  localparam int ETCC_REARM_CYC = (ETCC_REARM_TIME_NS * 1000) / ETCC_CLK_PERIOD_PS;
  typedef enum {ETCC_ARMED, ETCC_LOCKED} etcc_state_type;
endpackage

// ---- src/etcc_tick_if.sv ----
// interface carrying the counter tick from the divider to the counter core
// assumes both ends share mclk
interface etcc_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// ---- src/etcc_divider.sv ----
// vco tick divider: one tick every 8 or 20 vco reference ticks
// assumes vco_tick is a single-cycle pulse already in the mclk domain
module etcc_divider
  import etcc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic run,
  input wire logic vco_sel,
  input wire logic vco_third_tick,
  input wire logic vco_second_tick,
  etcc_tick_if.src tk
);
  logic [ETCC_DIV_W-1:0] div_q;
  logic src_tick;
  logic [ETCC_DIV_W-1:0] last;

  // ----------------------------------------
  // source pick and terminal count
  // ----------------------------------------
  // one select drives both source and ratio so they can never disagree
  always_comb begin
    src_tick = (vco_sel == ETCC_VCO_SECOND) ? vco_second_tick : vco_third_tick;
    last = (vco_sel == ETCC_VCO_SECOND) ? ETCC_DIV_W'(ETCC_DIV_SECOND - 1)
                                        : ETCC_DIV_W'(ETCC_DIV_THIRD - 1);
  end

  // prescaler held clear while the counter is disabled so phase restarts too
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
    end else if (!run) begin
      div_q <= '0;
    end else if (src_tick) begin
      div_q <= (div_q >= last) ? '0 : div_q + 1'b1;
    end
  end

  assign tk.tick = run && src_tick && (div_q >= last);
endmodule

// ---- src/etcc_core.sv ----
// elapsed time capture counter: 40-bit free counter, trigger capture, lock
// assumes spi read strobes come from the register slave on mclk; pins are async
// Functional notes
// - pin set to trigger function captures counter on chosen-polarity edge
// - after pin capture, ignore edges until low byte read; the lock also clears when enable is low or clear control is high
// - select 0 counts third vco divided by eight
// - trigger select 1 means pin, 0 means chip select
// - clear control 0 gives normal counting
// - spi mode captures on chip select falling edge
// - counter increments and wraps from maximum to zero
// - enable low holds counter at zero; starts from zero
// - vco select also steers reference validation vco
// - counter clock is third vco /8 or second vco /20
// - select 1 picks second vco
// - spi mode: after msb read, no recapture until lsb read; the lock also clears when enable is low or clear control is high
// - capture readable as 40 bits over byte registers
module etcc_core
  import etcc_pkg::*;
#(
  parameter int CNT_W = ETCC_CNT_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic counter_enable_bit,
  input wire logic counter_clear_control,
  input wire logic counter_vco_source_select,
  input wire logic trigger_source_select,
  input wire logic [5:0] pin_function_select,
  input wire logic pin_polarity_invert,
  input wire logic trig_pin,
  input wire logic spi_chip_select_n,
  input wire logic vco_third_tick,
  input wire logic vco_second_tick,
  input wire logic rd_lsb_stb,
  input wire logic rd_msb_stb,
  input wire logic [2:0] rd_byte_sel,
  output logic [7:0] rd_byte,
  output logic [CNT_W-1:0] capture_value_field,
  output logic capture_locked,
  output logic validation_vco_select
);
  etcc_tick_if tk();
  logic [CNT_W-1:0] cnt_q;
  logic [2:0] pin_sync_q;
  logic [2:0] cs_sync_q;
  logic pin_lvl_q;
  logic cs_lvl_q;
  logic pin_edge;
  logic cs_fall;
  logic run;
  logic cap;
  etcc_state_type st_q;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  assign run = counter_enable_bit && !counter_clear_control;
  assign validation_vco_select = counter_vco_source_select;

  etcc_divider u_div (
    .mclk(mclk),
    .resetn(resetn),
    .run(run),
    .vco_sel(counter_vco_source_select),
    .vco_third_tick(vco_third_tick),
    .vco_second_tick(vco_second_tick),
    .tk(tk)
  );

  // natural 40-bit overflow gives the wrap without a compare
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= CNT_W'(ETCC_CNT_RST);
    end else if (!run) begin
      cnt_q <= CNT_W'(ETCC_CNT_RST);
    end else if (tk.tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // trigger synchronisers
  // ----------------------------------------
  // three stages; change counts when stages two and three agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_sync_q <= '0;
      cs_sync_q <= 3'h7;
      pin_lvl_q <= 1'b0;
      cs_lvl_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], trig_pin ^ pin_polarity_invert};
      cs_sync_q <= {cs_sync_q[1:0], spi_chip_select_n};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_lvl_q <= pin_sync_q[2];
      end
      if (cs_sync_q[1] == cs_sync_q[2]) begin
        cs_lvl_q <= cs_sync_q[2];
      end
    end
  end

  assign pin_edge = (pin_sync_q[1] == pin_sync_q[2]) && pin_sync_q[2] && !pin_lvl_q;
  assign cs_fall = (cs_sync_q[1] == cs_sync_q[2]) && !cs_sync_q[2] && cs_lvl_q;

  // ----------------------------------------
  // capture and lock
  // ----------------------------------------
  always_comb begin
    if (trigger_source_select == ETCC_TRIG_PIN) begin
      cap = run && pin_edge && (pin_function_select == ETCC_PIN_FUNC_TRIG)
            && (st_q == ETCC_ARMED);
    end else begin
      cap = run && cs_fall && (st_q == ETCC_ARMED);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      capture_value_field <= '0;
    end else if (cap) begin
      capture_value_field <= cnt_q;
    end
  end

  // pin mode locks on capture; spi mode locks on msb read. an lsb read rearms,
  // and a trigger edge or msb read in that same cycle is ignored since st_q is still locked
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ETCC_ARMED;
    end else begin
      unique case (st_q)
        ETCC_ARMED: begin
          if (trigger_source_select == ETCC_TRIG_PIN && cap) begin
            st_q <= ETCC_LOCKED;
          end else if (trigger_source_select == ETCC_TRIG_SPI && rd_msb_stb) begin
            st_q <= ETCC_LOCKED;
          end
        end
        ETCC_LOCKED: begin
          if (rd_lsb_stb || !run) begin
            st_q <= ETCC_ARMED;
          end
        end
      endcase
    end
  end

  assign capture_locked = (st_q == ETCC_LOCKED);

  // ----------------------------------------
  // byte read port
  // ----------------------------------------
  // byte view of the held field; it only changes on cap, never mid-read
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_byte <= 8'h00;
    end else begin
      rd_byte <= (rd_byte_sel < 3'h5) ? capture_value_field[rd_byte_sel*8 +: 8] : 8'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_wrap;
    @(posedge mclk) disable iff (!resetn)
      (run && tk.tick && &cnt_q) |=> (cnt_q == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_hold_zero;
    @(posedge mclk) disable iff (!resetn)
      !counter_enable_bit |=> (cnt_q == '0);
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("counter not zero");

  property p_pin_lock;
    @(posedge mclk) disable iff (!resetn)
      (capture_locked && trigger_source_select && !rd_lsb_stb && run)
        |=> $stable(capture_value_field);
  endproperty
  a_pin_lock: assert property (p_pin_lock) else $error("capture changed while locked");

  property p_pin_cap;
    @(posedge mclk) disable iff (!resetn)
      (trigger_source_select && pin_edge && run && !capture_locked
       && pin_function_select == ETCC_PIN_FUNC_TRIG)
        |=> (capture_value_field == $past(cnt_q)) && capture_locked;
  endproperty
  a_pin_cap: assert property (p_pin_cap) else $error("pin edge missed");

  property p_spi_cap;
    @(posedge mclk) disable iff (!resetn)
      (!trigger_source_select && cs_fall && run && !capture_locked)
        |=> (capture_value_field == $past(cnt_q));
  endproperty
  a_spi_cap: assert property (p_spi_cap) else $error("cs fall missed");

  property p_msb_lock;
    @(posedge mclk) disable iff (!resetn)
      (!trigger_source_select && rd_msb_stb && !capture_locked) |=> capture_locked;
  endproperty
  a_msb_lock: assert property (p_msb_lock) else $error("msb read did not lock");

  property p_div8;
    @(posedge mclk) disable iff (!resetn)
      (tk.tick && !counter_vco_source_select && run) |-> (u_div.div_q == 5'h07);
  endproperty
  a_div8: assert property (p_div8) else $error("third vco ratio wrong");

  property p_div20;
    @(posedge mclk) disable iff (!resetn)
      (tk.tick && counter_vco_source_select && run) |-> (u_div.div_q == 5'h13);
  endproperty
  a_div20: assert property (p_div20) else $error("second vco ratio wrong");
endmodule

// ---- verification/etcc_host_model.sv ----
// host-side model: vco tick source plus trigger, chip select and read strobes
// assumes the bench calls its tasks from the mclk falling edge
module etcc_host_model (
  input wire logic mclk,
  output logic trig_pin,
  output logic spi_chip_select_n,
  output logic vco_third_tick,
  output logic vco_second_tick,
  output logic rd_lsb_stb,
  output logic rd_msb_stb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tk;
  logic [1:0] ph;
  // ---------------------------------------
  // vco ticks
  // ---------------------------------------
  // third vco ticks every other cycle, second every third cycle, so a
  // swapped source shows up as a wrong count rate
  initial tk = 1'b0;
  initial ph = 2'h0;
  always @(negedge mclk) tk <= ~tk;
  always @(negedge mclk) ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
  assign vco_third_tick = tk;
  assign vco_second_tick = (ph == 2'h0);
  initial begin
    {trig_pin, rd_lsb_stb, rd_msb_stb} = 3'h0;
    spi_chip_select_n = 1'b1;
  end
  // ---------------------------------------
  // host actions
  // ---------------------------------------
  // pin change, then held well past 10 ns and clear of any enabling write
  task automatic pin_to(input logic v);
    @(negedge mclk) trig_pin = v;
    repeat (4) @(negedge mclk);
  endtask
  // short chip select frame; the line returns high between frames
  task automatic cs_frame();
    @(negedge mclk) spi_chip_select_n = 1'b0;
    repeat (4) @(negedge mclk);
    spi_chip_select_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
  // capture byte read; host then keeps 1 us quiet before any new trigger
  task automatic rd_stb(input logic msb);
    @(negedge mclk) rd_msb_stb = msb;
    rd_lsb_stb = ~msb;
    @(negedge mclk) {rd_lsb_stb, rd_msb_stb} = 2'h0;
    repeat (100) @(negedge mclk);
  endtask
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the elapsed time capture counter
// assumes etcc_host_model drives pins and ticks; bench drives levels on negedge
module tb;
  import etcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, resetn, en, clr, vsel, tsel, pol, trig, csn, t3, t2, lsb, msb;
  logic locked, vvs;
  logic [5:0] func;
  logic [2:0] sel;
  logic [7:0] rdb;
  logic [39:0] cap, c0, c1;
  int n_mismatch = 0, total_checks = 0, cyc = 0, t0;
  etcc_core u_etcc_core (
    .mclk(mclk),
    .resetn(resetn),
    .counter_enable_bit(en),
    .counter_clear_control(clr),
    .counter_vco_source_select(vsel),
    .trigger_source_select(tsel),
    .pin_function_select(func),
    .pin_polarity_invert(pol),
    .trig_pin(trig),
    .spi_chip_select_n(csn),
    .vco_third_tick(t3),
    .vco_second_tick(t2),
    .rd_lsb_stb(lsb),
    .rd_msb_stb(msb),
    .rd_byte_sel(sel),
    .rd_byte(rdb),
    .capture_value_field(cap),
    .capture_locked(locked),
    .validation_vco_select(vvs)
  );
  etcc_host_model u_etcc_host_model (
    .mclk(mclk),
    .trig_pin(trig),
    .spi_chip_select_n(csn),
    .vco_third_tick(t3),
    .vco_second_tick(t2),
    .rd_lsb_stb(lsb),
    .rd_msb_stb(msb)
  );
  // ---------------------------------------
  // clock, cycle count, checks
  // ---------------------------------------
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc++;
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // counts gained over a span, within two ticks since sync latency jitters
  task automatic span(input logic [39:0] a, input logic [39:0] b, input int n, input int dv);
    int d;
    d = int'(b - a) - n / dv;
    check({39'h0, d >= -2 && d <= 2}, 40'h1);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // the sequence needs some 2700 cycles; cut off well beyond that
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    tally_and_finish();
  end
  // ---------------------------------------
  // scenarios
  // ---------------------------------------
  initial begin
    {resetn, en, clr, vsel, tsel, pol} = 6'h0;
    func = ETCC_PIN_FUNC_TRIG;
    sel = 3'h0;
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    u_etcc_host_model.cs_frame();
    check(cap, 40'h0);
    tsel = ETCC_TRIG_PIN;
    en = 1'b1;
    u_etcc_host_model.pin_to(1'b1);
    check({39'h0, locked}, 40'h1);
    c0 = cap;
    t0 = cyc;
    repeat (800) @(negedge mclk);
    u_etcc_host_model.pin_to(1'b0);
    u_etcc_host_model.pin_to(1'b1);
    check(cap, c0);
    // every byte of the held snapshot, then one index past the end
    for (int i = 0; i < 6; i++) begin
      sel = 3'(i);
      @(negedge mclk);
      check({32'h0, rdb}, (i < 5) ? (c0 >> (8 * i)) & 40'hff : 40'h0);
    end
    u_etcc_host_model.rd_stb(1'b0);
    check({39'h0, locked}, 40'h0);
    u_etcc_host_model.pin_to(1'b0);
    u_etcc_host_model.pin_to(1'b1);
    span(c0, cap, cyc - t0, 16);
    u_etcc_host_model.rd_stb(1'b0);
    func = 6'h26;
    u_etcc_host_model.pin_to(1'b0);
    u_etcc_host_model.pin_to(1'b1);
    check({39'h0, locked}, 40'h0);
    func = ETCC_PIN_FUNC_TRIG;
    pol = 1'b1;
    vsel = ETCC_VCO_SECOND;
    // let the inverted level settle first, or the one-cycle dip is filtered out
    repeat (4) @(negedge mclk);
    u_etcc_host_model.pin_to(1'b0);
    check(40'(vvs), 40'h1);
    c1 = cap;
    t0 = cyc;
    repeat (800) @(negedge mclk);
    u_etcc_host_model.rd_stb(1'b0);
    u_etcc_host_model.pin_to(1'b1);
    u_etcc_host_model.pin_to(1'b0);
    span(c1, cap, cyc - t0, 60);
    u_etcc_host_model.rd_stb(1'b0);
    // toggling enable restarts from zero; chip select triggers from here on
    en = 1'b0;
    vsel = ETCC_VCO_THIRD;
    tsel = ETCC_TRIG_SPI;
    @(negedge mclk) en = 1'b1;
    t0 = cyc;
    u_etcc_host_model.cs_frame();
    span(40'h0, cap, cyc - t0, 16);
    c1 = cap;
    repeat (300) @(negedge mclk);
    u_etcc_host_model.cs_frame();
    span(40'h0, cap, cyc - t0, 16);
    c1 = cap;
    u_etcc_host_model.rd_stb(1'b1);
    u_etcc_host_model.cs_frame();
    check(cap, c1);
    u_etcc_host_model.rd_stb(1'b0);
    u_etcc_host_model.cs_frame();
    span(40'h0, cap, cyc - t0, 16);
    // clear control high holds the count at zero although enable stays set
    clr = 1'b1;
    repeat (50) @(negedge mclk);
    clr = 1'b0;
    t0 = cyc;
    u_etcc_host_model.cs_frame();
    span(40'h0, cap, cyc - t0, 16);
    tally_and_finish();
  end
endmodule
